//--- bench/fmc_micro_partner.sv
// Datapath-side model feeding sum, product nibbles and quotient bits
`timescale 1ns/1ns
module fmc_micro_partner (
    // Clock
    input wire logic i_core_clk,
    // Datapath values
    output logic [31:0] o_sum_data,
    output logic [3:0] o_pp_low_nibble,
    output logic o_quot_bit
);
    logic [31:0] cnt_reg = 32'h0000_0000;
    // Values change every cycle so a stale sample shows up
    always_ff @(posedge i_core_clk) begin
        cnt_reg <= cnt_reg + 32'h1357_9BDF;
    end
    assign o_sum_data = cnt_reg;
    assign o_pp_low_nibble = cnt_reg[7:4];
    // Constant ones fill the quotient fastest
    assign o_quot_bit = 1'b1;
endmodule

//--- bench/tb.sv
// Self-checking bench for the multiplier sequencer
`timescale 1ns/1ns
module tb;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pw = 0, ok;
    logic [7:0] pa = 8'h00;
    logic [31:0] pwd = 32'h0, rd, prdata, sum, uh, lh;
    logic pready, perr, err, fin, rfs, bal, bbl, qb, men;
    int merge_cyc = 0;
    logic [3:0] ppn;
    // Pipe start plus single, double, integer, then pipe start plus quotient
    logic [3:0] ops [4] = '{4'h8, 4'h9, 4'hA, 4'hC};
    int error_cnt = 0, total_checks = 0, cyc = 0;
    initial forever #4 clk = ~clk;
    fmc_micro_partner PART(.i_core_clk(clk), .o_sum_data(sum), .o_pp_low_nibble(ppn), .o_quot_bit(qb));
    fmc_sequencer DUT(.i_core_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pw),
        .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prdata), .o_pready(pready), .o_pslverr(perr),
        .i_sum_data(sum), .i_pp_low_nibble(ppn), .i_quot_bit(qb), .o_arith_finished(fin),
        .o_low_half_merge_en(men), .o_merge_nibble(), .o_clear_carries(), .o_result_from_sum(rfs),
        .o_busa_from_low(bal), .o_busb_from_low(bbl), .o_upper_hold(uh), .o_low_half(lh));
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; pw <= w; pa <= a; pwd <= d; pen <= 1'b0;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic wait_done();
        ok = 1'b0;
        for (int i = 0; i < 300 && !ok; i++) begin
            apb(1'b0, fmc_pkg::ADDR_STATUS, 32'h0);
            ok = (rd[3:0] === 4'hC);
        end
    endtask
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", error_cnt, total_checks);
        if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Ceiling well above the four operations
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (men === 1'b1) merge_cyc <= merge_cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("finished_reset", 32'h0, {31'h0, fin});
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, err});
        chk("unmapped_rd", 32'h0, rd);
        apb(1'b1, fmc_pkg::ADDR_CTRL, 32'h0);
        repeat (60) @(posedge clk);
        apb(1'b0, fmc_pkg::ADDR_STATUS, 32'h0);
        chk("idle_loop", 32'h1, {31'h0, rd[3:0] <= 4'h3});
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, fmc_pkg::ADDR_CTRL, {28'h0, ops[k]});
            wait_done();
            chk("done_reached", 32'h1, {31'h0, ok});
            // Long enough to pass one full microcycle in done
            repeat (40) @(posedge clk);
            chk("finished", 32'h1, {31'h0, fin});
            chk("from_sum", {31'h0, k < 3}, {31'h0, rfs});
            chk("busb_low", {31'h0, k == 1}, {31'h0, bbl});
            chk("busa_low", {31'h0, k == 2}, {31'h0, bal});
            if (k == 3) chk("quot_full", 32'h1, {31'h0, |uh[29:28]});
            // Six merge ticks of six clocks each on the second double pass
            if (k == 1) chk("merge_cycles", 32'h0000_0024, merge_cyc);
            // Single precision quotient ones fill both registers from bit 4 up
            if (k == 3) chk("quot_low", 32'h1, {31'h0, lh == 32'h1FFF_FFF0 || lh == 32'h3FFF_FFF0
                || lh == 32'h7FFF_FFF0});
            if (k == 3) chk("quot_concat", lh, uh);
            apb(1'b1, fmc_pkg::ADDR_CTRL, 32'h0);
            apb(1'b1, fmc_pkg::ADDR_OPLOAD, 32'hF);
            repeat (20) @(posedge clk);
            chk("released", 32'h0, {31'h0, fin});
            apb(1'b1, fmc_pkg::ADDR_OPLOAD, 32'h0);
        end
        tally_and_finish();
    end
endmodule

//--- core/fmc_pkg.sv
// Constants, states and register map of the fraction multiplier sequencer
// Functional notes
// - Test with single product goes straight to pipe, using init nibble data.
// - Pipe accumulates until pipe end tick, then moves to carry merge.
// - Carry merge holds registers, latches sum into upper hold for 150 ns.
// - Carry end goes to done if pass flag clear, else half transfer.
// - Done raises finished, holds everything until init code is issued.
// - Single product result is routed straight from the sum adder.
// - Reload state loads new nibble counter data for a double product.
// - Double: wait state sets pass flag after 100 ns, pipe after 150 ns.
// - First double pass: upper 32 bits to upper hold, lower in low half.
// - Half transfer: four ticks move halves down, clear flag and carries.
// - Second double pass merges saved low half, 4 bits per tick, six ticks.
// - After 20 merged bits go to zero feed until pipe end tick.
// - Double done: upper bits from sum adder on A, low half on B.
// - Integer product reloads nibble counter, test selects wait state.
// - Integer: one tick after pass flag sets in wait (150 ns), enter integer pipeline.
// - Integer pipeline ends in done when nibble count equals 3.
// - Integer done: upper half on A, next microcycle lower half on A.
// - Division: upper hold and low half form one quotient register.
// - Test with pipe start and quotient op enters divide wait.
// - Divide wait entered with odd nibble count, left when even.
// - Quotient shift each even tick into bit 4 of low half, and of upper half unless double.
// - Quotient full at bits 28/29, checked at T100, goes to done.
// - State register advances every 50 ns from state and flags.
// - Test without pipe start returns to init and keeps waiting.
package fmc_pkg;
    typedef enum logic [3:0] {
        FMC_INIT, FMC_SYNC, FMC_RELOAD, FMC_TEST, FMC_DIV_WAIT, FMC_QUOT_SHIFT, FMC_WAIT,
        FMC_INT_PIPE, FMC_PIPE, FMC_CARRY_MERGE, FMC_HALF_TRANSFER, FMC_ZERO_FEED, FMC_DONE
    } fmc_state_t;

    // Operation kinds held in the control register
    localparam logic [1:0] OP_SINGLE = 2'h0;
    localparam logic [1:0] OP_DOUBLE = 2'h1;
    localparam logic [1:0] OP_INTEGER = 2'h2;

    // Timing
    localparam int CLK_NS = 8;
    localparam int TICK_NS = 50;
    localparam int TICK_CYC = TICK_NS / CLK_NS;
    localparam int FLAG_NS = 100;
    localparam int WAIT_NS = 150;
    localparam int CARRY_NS = 150;
    localparam int DIV_WAIT_NS = 100;
    localparam logic [3:0] FLAG_TICKS = 4'(FLAG_NS / TICK_NS);
    localparam logic [3:0] WAIT_TICKS = 4'(WAIT_NS / TICK_NS);
    localparam logic [3:0] CARRY_TICKS = 4'(CARRY_NS / TICK_NS);
    localparam logic [3:0] DIV_WAIT_TICKS = 4'(DIV_WAIT_NS / TICK_NS);
    localparam logic [3:0] HALF_TRANSFER_STATE_TICKS = 4'h4;
    localparam logic [3:0] PIPE_TICKS = 4'h8;
    localparam logic [2:0] MERGE_TAIL_CNT = 3'h5;
    localparam logic [1:0] PHASE_T100 = 2'h2;

    // Nibble counter loads
    localparam logic [3:0] NIB_SINGLE = 4'hA;
    localparam logic [3:0] NIB_DOUBLE = 4'h2;
    localparam logic [3:0] NIB_INTEGER = 4'h6;
    localparam logic [3:0] NIB_INT_END = 4'h3;
    localparam logic [3:0] INIT_CODE = 4'hF;

    // Quotient
    localparam int QBIT_POS = 4;
    localparam int QFULL_LO = 28;
    localparam int QFULL_HI = 29;

    // APB map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_OPLOAD = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_UPPER = 8'h0C;
    localparam logic [7:0] ADDR_LOW = 8'h10;
    localparam logic [7:0] ADDR_ACCUM = 8'h14;
    localparam logic [3:0] CTRL_RESET = 4'h0;
endpackage

//--- core/fmc_sequencer.sv
// Fraction multiplier state sequencer with APB register access
`timescale 1ns/1ns
module fmc_sequencer (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Datapath inputs
    input wire logic [31:0] i_sum_data,
    input wire logic [3:0] i_pp_low_nibble,
    input wire logic i_quot_bit,
    // Sequencer outputs
    output logic o_arith_finished,
    output logic o_low_half_merge_en,
    output logic [3:0] o_merge_nibble,
    output logic o_clear_carries,
    output logic o_result_from_sum,
    output logic o_busa_from_low,
    output logic o_busb_from_low,
    output logic [31:0] o_upper_hold,
    output logic [31:0] o_low_half
);
    fmc_pkg::fmc_state_t state_reg;
    logic [2:0] div_cnt_reg;
    logic tick_reg;
    logic [1:0] phase_reg;
    logic [3:0] nibble_reg;
    logic [3:0] st_cnt_reg;
    logic [3:0] pipe_cnt_reg;
    logic [2:0] merge_cnt_reg;
    logic pass_flag_reg;
    logic [31:0] upper_reg;
    logic [31:0] low_reg;
    logic [31:0] accum_reg;
    logic [1:0] op_kind_reg;
    logic quot_op_reg;
    logic pipe_start_reg;
    logic [3:0] opload_reg;
    logic init_req_reg;
    logic is_double;
    logic is_int;
    logic merge_now;
    logic quot_full;
    logic wr_en;
    logic rd_en;

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == fmc_pkg::ADDR_CTRL) || (a == fmc_pkg::ADDR_OPLOAD) || (a == fmc_pkg::ADDR_STATUS)
            || (a == fmc_pkg::ADDR_UPPER) || (a == fmc_pkg::ADDR_LOW) || (a == fmc_pkg::ADDR_ACCUM);
    endfunction

    assign is_double = (op_kind_reg == fmc_pkg::OP_DOUBLE);
    assign is_int = (op_kind_reg == fmc_pkg::OP_INTEGER);
    assign wr_en = i_psel && i_penable && !o_pready && i_pwrite;
    assign rd_en = i_psel && i_penable && !o_pready && !i_pwrite;
    // Merge while in second-pass pipe, and once more on entry to zero feed
    assign merge_now = (!pass_flag_reg && is_double)
        && ((state_reg == fmc_pkg::FMC_PIPE) || (state_reg == fmc_pkg::FMC_ZERO_FEED && st_cnt_reg == 4'h0));
    assign quot_full = upper_reg[fmc_pkg::QFULL_LO] || upper_reg[fmc_pkg::QFULL_HI];

    // 50 ns tick divider and microcycle phase
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            div_cnt_reg <= 3'h0;
            tick_reg <= 1'b0;
            phase_reg <= 2'h0;
        end else begin
            tick_reg <= (div_cnt_reg == 3'(fmc_pkg::TICK_CYC - 1));
            if (div_cnt_reg == 3'(fmc_pkg::TICK_CYC - 1)) begin
                div_cnt_reg <= 3'h0;
            end else begin
                div_cnt_reg <= div_cnt_reg + 3'h1;
            end
            if (tick_reg) begin
                phase_reg <= phase_reg + 2'h1;
            end
        end
    end

    // APB slave, one wait state
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0000_0000;
            op_kind_reg <= 2'h0;
            quot_op_reg <= 1'b0;
            pipe_start_reg <= 1'b0;
            opload_reg <= 4'h0;
            init_req_reg <= 1'b0;
        end else begin
            o_pready <= i_psel && i_penable && !o_pready;
            o_pslverr <= i_psel && i_penable && !o_pready && !addr_ok(i_paddr);
            if (tick_reg) begin
                init_req_reg <= 1'b0;
            end
            if (wr_en && i_paddr == fmc_pkg::ADDR_CTRL) begin
                {pipe_start_reg, quot_op_reg, op_kind_reg} <= i_pwdata[3:0];
            end
            if (wr_en && i_paddr == fmc_pkg::ADDR_OPLOAD) begin
                opload_reg <= i_pwdata[3:0];
                if (i_pwdata[3:0] == fmc_pkg::INIT_CODE) begin
                    init_req_reg <= 1'b1;
                end
            end
            if (rd_en) begin
                case (i_paddr)
                    fmc_pkg::ADDR_CTRL: o_prdata <= {28'h0, pipe_start_reg, quot_op_reg, op_kind_reg};
                    fmc_pkg::ADDR_OPLOAD: o_prdata <= {28'h0, opload_reg};
                    fmc_pkg::ADDR_STATUS: o_prdata <= {16'h0, nibble_reg, 1'b0, quot_full,
                        o_arith_finished, pass_flag_reg, 4'h0, state_reg};
                    fmc_pkg::ADDR_UPPER: o_prdata <= upper_reg;
                    fmc_pkg::ADDR_LOW: o_prdata <= low_reg;
                    fmc_pkg::ADDR_ACCUM: o_prdata <= accum_reg;
                    default: o_prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // State register, advanced on the 50 ns tick only
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state_reg <= fmc_pkg::FMC_INIT;
            st_cnt_reg <= 4'h0;
        end else if (tick_reg) begin
            st_cnt_reg <= st_cnt_reg + 4'h1;
            if (init_req_reg) begin
                state_reg <= fmc_pkg::FMC_INIT;
                st_cnt_reg <= 4'h0;
            end else begin
                case (state_reg)
                    fmc_pkg::FMC_INIT: begin
                        state_reg <= fmc_pkg::FMC_SYNC;
                        st_cnt_reg <= 4'h0;
                    end
                    fmc_pkg::FMC_SYNC: begin
                        state_reg <= fmc_pkg::FMC_RELOAD;
                        st_cnt_reg <= 4'h0;
                    end
                    fmc_pkg::FMC_RELOAD: begin
                        state_reg <= fmc_pkg::FMC_TEST;
                        st_cnt_reg <= 4'h0;
                    end
                    fmc_pkg::FMC_TEST: begin
                        st_cnt_reg <= 4'h0;
                        if (!pipe_start_reg) begin
                            state_reg <= fmc_pkg::FMC_INIT;
                        end else if (quot_op_reg) begin
                            state_reg <= fmc_pkg::FMC_DIV_WAIT;
                        end else if (is_double || is_int) begin
                            state_reg <= fmc_pkg::FMC_WAIT;
                        end else begin
                            state_reg <= fmc_pkg::FMC_PIPE;
                        end
                    end
                    fmc_pkg::FMC_DIV_WAIT: begin
                        if (!nibble_reg[0]) begin
                            state_reg <= fmc_pkg::FMC_QUOT_SHIFT;
                            st_cnt_reg <= 4'h0;
                        end
                    end
                    fmc_pkg::FMC_QUOT_SHIFT: begin
                        if (quot_full && phase_reg == fmc_pkg::PHASE_T100) begin
                            state_reg <= fmc_pkg::FMC_DONE;
                        end
                    end
                    fmc_pkg::FMC_WAIT: begin
                        if (st_cnt_reg == fmc_pkg::WAIT_TICKS - 4'h1) begin
                            state_reg <= is_int ? fmc_pkg::FMC_INT_PIPE : fmc_pkg::FMC_PIPE;
                            st_cnt_reg <= 4'h0;
                        end
                    end
                    fmc_pkg::FMC_INT_PIPE: begin
                        if (nibble_reg == fmc_pkg::NIB_INT_END) begin
                            state_reg <= fmc_pkg::FMC_DONE;
                        end
                    end
                    fmc_pkg::FMC_PIPE: begin
                        st_cnt_reg <= 4'h0;
                        if (pipe_cnt_reg == fmc_pkg::PIPE_TICKS - 4'h1) begin
                            state_reg <= fmc_pkg::FMC_CARRY_MERGE;
                        end else if (merge_now && merge_cnt_reg == fmc_pkg::MERGE_TAIL_CNT - 3'h1) begin
                            state_reg <= fmc_pkg::FMC_ZERO_FEED;
                        end
                    end
                    fmc_pkg::FMC_ZERO_FEED: begin
                        if (pipe_cnt_reg == fmc_pkg::PIPE_TICKS - 4'h1) begin
                            state_reg <= fmc_pkg::FMC_CARRY_MERGE;
                            st_cnt_reg <= 4'h0;
                        end
                    end
                    fmc_pkg::FMC_CARRY_MERGE: begin
                        if (st_cnt_reg == fmc_pkg::CARRY_TICKS - 4'h1) begin
                            state_reg <= pass_flag_reg ? fmc_pkg::FMC_HALF_TRANSFER : fmc_pkg::FMC_DONE;
                            st_cnt_reg <= 4'h0;
                        end
                    end
                    fmc_pkg::FMC_HALF_TRANSFER: begin
                        if (st_cnt_reg == fmc_pkg::HALF_TRANSFER_STATE_TICKS - 4'h1) begin
                            state_reg <= fmc_pkg::FMC_PIPE;
                            st_cnt_reg <= 4'h0;
                        end
                    end
                    fmc_pkg::FMC_DONE: begin
                        state_reg <= fmc_pkg::FMC_DONE;
                    end
                    default: begin
                        state_reg <= fmc_pkg::FMC_INIT;
                        st_cnt_reg <= 4'h0;
                    end
                endcase
            end
        end
    end

    // Pass flag, nibble counter, pipe and merge counters
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            pass_flag_reg <= 1'b0;
            nibble_reg <= fmc_pkg::NIB_SINGLE;
            pipe_cnt_reg <= 4'h0;
            merge_cnt_reg <= 3'h0;
        end else if (tick_reg) begin
            nibble_reg <= nibble_reg + 4'h1;
            case (state_reg)
                fmc_pkg::FMC_INIT: begin
                    nibble_reg <= fmc_pkg::NIB_SINGLE;
                    // Cleared here so a single product after a double starts fresh
                    pipe_cnt_reg <= 4'h0;
                    merge_cnt_reg <= 3'h0;
                end
                fmc_pkg::FMC_SYNC: begin
                    pass_flag_reg <= 1'b0;
                end
                fmc_pkg::FMC_RELOAD: begin
                    if (is_int) begin
                        nibble_reg <= fmc_pkg::NIB_INTEGER;
                    end else if (is_double) begin
                        nibble_reg <= fmc_pkg::NIB_DOUBLE;
                    end
                end
                fmc_pkg::FMC_WAIT: begin
                    if (st_cnt_reg == fmc_pkg::FLAG_TICKS - 4'h1) begin
                        pass_flag_reg <= 1'b1;
                    end
                end
                fmc_pkg::FMC_PIPE, fmc_pkg::FMC_ZERO_FEED: begin
                    pipe_cnt_reg <= pipe_cnt_reg + 4'h1;
                    if (merge_now) begin
                        merge_cnt_reg <= merge_cnt_reg + 3'h1;
                    end
                end
                fmc_pkg::FMC_HALF_TRANSFER: begin
                    pass_flag_reg <= 1'b0;
                    pipe_cnt_reg <= 4'h0;
                end
                fmc_pkg::FMC_DONE: begin
                    nibble_reg <= nibble_reg;
                end
                default: begin
                end
            endcase
        end
    end

    // Datapath registers
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            upper_reg <= 32'h0000_0000;
            low_reg <= 32'h0000_0000;
            accum_reg <= 32'h0000_0000;
            o_merge_nibble <= 4'h0;
        end else if (tick_reg) begin
            case (state_reg)
                fmc_pkg::FMC_TEST: begin
                    upper_reg <= 32'h0000_0000;
                    low_reg <= 32'h0000_0000;
                    accum_reg <= 32'h0000_0000;
                end
                fmc_pkg::FMC_PIPE, fmc_pkg::FMC_ZERO_FEED, fmc_pkg::FMC_INT_PIPE: begin
                    // Product LSBs enter the top, saved bits leave the bottom
                    low_reg <= {i_pp_low_nibble, low_reg[31:4]};
                    o_merge_nibble <= merge_now ? low_reg[3:0] : 4'h0;
                    accum_reg <= i_sum_data;
                end
                fmc_pkg::FMC_CARRY_MERGE: begin
                    upper_reg <= i_sum_data;
                end
                fmc_pkg::FMC_HALF_TRANSFER: begin
                    accum_reg <= {low_reg[7:0], accum_reg[31:8]};
                    low_reg <= {upper_reg[7:0], low_reg[31:8]};
                    upper_reg <= {8'h00, upper_reg[31:8]};
                end
                fmc_pkg::FMC_QUOT_SHIFT: begin
                    if (!nibble_reg[0]) begin
                        // Concatenated shift, low MSB feeds upper LSB
                        low_reg <= {low_reg[30:fmc_pkg::QBIT_POS], i_quot_bit, low_reg[2:0], 1'b0};
                        upper_reg <= {upper_reg[30:fmc_pkg::QBIT_POS],
                            is_double ? upper_reg[3] : i_quot_bit, upper_reg[2:0], low_reg[31]};
                    end
                end
                default: begin
                end
            endcase
        end
    end
    // Control outputs, all registered
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_arith_finished <= 1'b0;
            o_low_half_merge_en <= 1'b0;
            o_clear_carries <= 1'b0;
            o_result_from_sum <= 1'b0;
            o_busa_from_low <= 1'b0;
            o_busb_from_low <= 1'b0;
            o_upper_hold <= 32'h0000_0000;
            o_low_half <= 32'h0000_0000;
        end else begin
            o_upper_hold <= upper_reg;
            o_low_half <= low_reg;
            o_arith_finished <= (state_reg == fmc_pkg::FMC_DONE);
            o_low_half_merge_en <= merge_now;
            o_clear_carries <= (state_reg == fmc_pkg::FMC_HALF_TRANSFER) || (state_reg == fmc_pkg::FMC_TEST);
            o_result_from_sum <= (state_reg == fmc_pkg::FMC_DONE) && !quot_op_reg;
            o_busb_from_low <= (state_reg == fmc_pkg::FMC_DONE) && is_double;
            // Integer result: upper half first microcycle, lower half the next
            if (state_reg != fmc_pkg::FMC_DONE || !is_int) begin
                o_busa_from_low <= 1'b0;
            end else if (tick_reg && phase_reg == 2'h3) begin
                o_busa_from_low <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    sequence s_carry_enter;
        tick_reg && state_reg == fmc_pkg::FMC_PIPE && pipe_cnt_reg == fmc_pkg::PIPE_TICKS - 4'h1 && !init_req_reg;
    endsequence
    property p_pipe_to_carry;
        s_carry_enter |=> state_reg == fmc_pkg::FMC_CARRY_MERGE;
    endproperty
    a_pipe_to_carry: assert property (p_pipe_to_carry) else $error("pipe end did not reach carry merge");
    property p_single_test;
        tick_reg && state_reg == fmc_pkg::FMC_TEST && pipe_start_reg && !quot_op_reg
            && op_kind_reg == fmc_pkg::OP_SINGLE && !init_req_reg |=> state_reg == fmc_pkg::FMC_PIPE;
    endproperty
    a_single_test: assert property (p_single_test) else $error("single product skipped pipe");
    property p_no_start;
        tick_reg && state_reg == fmc_pkg::FMC_TEST && !pipe_start_reg |=> state_reg == fmc_pkg::FMC_INIT;
    endproperty
    a_no_start: assert property (p_no_start) else $error("test without start left idle loop");
    property p_carry_exit;
        tick_reg && state_reg == fmc_pkg::FMC_CARRY_MERGE && st_cnt_reg == fmc_pkg::CARRY_TICKS - 4'h1
            && !init_req_reg |=> state_reg == (pass_flag_reg ? fmc_pkg::FMC_HALF_TRANSFER : fmc_pkg::FMC_DONE);
    endproperty
    a_carry_exit: assert property (p_carry_exit) else $error("wrong exit from carry merge");
    property p_done_holds;
        state_reg == fmc_pkg::FMC_DONE && !init_req_reg |=> state_reg == fmc_pkg::FMC_DONE;
    endproperty
    a_done_holds: assert property (p_done_holds) else $error("done left without init code");
    property p_finished;
        state_reg == fmc_pkg::FMC_DONE ##1 state_reg == fmc_pkg::FMC_DONE |-> o_arith_finished;
    endproperty
    a_finished: assert property (p_finished) else $error("finished not raised in done");
    property p_wait_flag;
        tick_reg && state_reg == fmc_pkg::FMC_WAIT && st_cnt_reg == fmc_pkg::FLAG_TICKS - 4'h1 |=> pass_flag_reg;
    endproperty
    a_wait_flag: assert property (p_wait_flag) else $error("pass flag not set in wait");
    property p_int_end;
        tick_reg && state_reg == fmc_pkg::FMC_INT_PIPE && nibble_reg == fmc_pkg::NIB_INT_END
            && !init_req_reg |=> state_reg == fmc_pkg::FMC_DONE;
    endproperty
    a_int_end: assert property (p_int_end) else $error("integer pipe missed count 3");
    property p_half_transfer_state_clear;
        tick_reg && state_reg == fmc_pkg::FMC_HALF_TRANSFER |=> !pass_flag_reg && o_clear_carries;
    endproperty
    a_half_transfer_state_clear: assert property (p_half_transfer_state_clear) else $error("half transfer kept flag or carries");
    property p_div_wait;
        tick_reg && state_reg == fmc_pkg::FMC_DIV_WAIT && nibble_reg[0] |=> state_reg != fmc_pkg::FMC_QUOT_SHIFT;
    endproperty
    a_div_wait: assert property (p_div_wait) else $error("divide wait left on odd count");
    property p_init_code;
        tick_reg && init_req_reg |=> state_reg == fmc_pkg::FMC_INIT;
    endproperty
    a_init_code: assert property (p_init_code) else $error("init code ignored");
endmodule
